// ===== inc/mti_defines.svh
// Constants of the multifunction terminal block: offsets, fields, resets, timing.
// Assumes a 20 MHz reference clock and a byte-addressed 32-bit register port.
`ifndef MTI_DEFINES_SVH
`define MTI_DEFINES_SVH

// Register byte offsets
`define MTI_REG_CTRL 8'h00
`define MTI_REG_IN_POL 8'h04
`define MTI_REG_OUT_POL 8'h08
`define MTI_REG_FILT 8'h0C
`define MTI_REG_TMR_ON 8'h10
`define MTI_REG_TMR_OFF 8'h14
`define MTI_REG_AUX_SEL 8'h18
`define MTI_REG_STATUS 8'h1C
`define MTI_REG_IRQ_STAT 8'h20
`define MTI_REG_IRQ_MASK 8'h24
`define MTI_REG_FUNC_BASE 8'h40
`define MTI_REG_FUNC_LAST 8'h58

// Control register fields
`define MTI_CTRL_LATCH 0
`define MTI_CTRL_SRC_LO 1
`define MTI_CTRL_TRIP_CLR 3

// Terminal bit positions (leftmost keypad digit is bit 10)
`define MTI_T_FWD 10
`define MTI_T_RST 7

// Input function codes
`define MTI_FN_NONE 5'h00
`define MTI_FN_EXT_TRIP 5'h0D
`define MTI_FN_TIMER 5'h11
`define MTI_FN_GAIN 5'h13
`define MTI_FN_PREMAG 5'h16
`define MTI_FN_TRQ_BIAS 5'h19
`define MTI_FN_SAFETY 5'h1A
`define MTI_FN_BATTERY 5'h1D

// Interrupt status bits
`define MTI_IRQ_TRIP 0
`define MTI_IRQ_REJECT 1
`define MTI_IRQ_TIMER 2

// Reset values
`define MTI_IN_POL_RST 11'h000
`define MTI_OUT_POL_RST 4'h0
`define MTI_FILT_RST 8'h04
`define MTI_TMR_RST 16'h0001

// Timing: figures in ns, counts derived from the clock period
`define MTI_CLK_NS 50
`define MTI_FILT_STEP_NS 2500000
`define MTI_TMR_STEP_NS 100000000
`define MTI_FILT_STEP_CYC (`MTI_FILT_STEP_NS / `MTI_CLK_NS)
`define MTI_TMR_STEP_CYC (`MTI_TMR_STEP_NS / `MTI_CLK_NS)

`endif

// ===== inc/mti_pkg.sv
// Types shared by the multifunction terminal block modules.
// Assumes the constants header is included by every user.
package mti_pkg;

  // Auxiliary output source select
  typedef enum logic [1:0] {MTI_AUX_NONE, MTI_AUX_TIMER, MTI_AUX_TRIP, MTI_AUX_RUN} mti_aux_t;

  // Torque offset source select
  typedef enum logic [1:0] {MTI_SRC_NONE, MTI_SRC_ANALOG, MTI_SRC_KEYPAD, MTI_SRC_CAN} mti_src_t;

  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] out;
    logic [10:0][7:0] cnt;
  } mti_filt_st_t;

  typedef struct packed {
    logic out;
    logic [15:0] cnt;
  } mti_tmr_st_t;

  typedef struct packed {
    logic [10:0] in_pol;
    logic [3:0] out_pol;
    logic [7:0] filt;
    logic [15:0] tmr_on;
    logic [15:0] tmr_off;
    logic [3:0][1:0] aux_sel;
    logic latch;
    logic [1:0] src;
    logic [6:0][4:0] func;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic trip;
    logic flash;
    logic tmr_q;
    logic [31:0] filt_div;
    logic [31:0] tmr_div;
    logic filt_tick;
    logic tmr_tick;
    logic [31:0] rdata;
    logic pwm_en;
    logic coast;
    logic gain2;
    logic premag;
    logic bias_en;
    logic battery;
    logic [3:0] aux;
    logic irq;
  } mti_top_st_t;

endpackage

// ===== rtl/mti_in_filter.sv
// Input conditioning for the eleven terminals: synchroniser, polarity, low-pass.
// Assumes raw terminals are asynchronous and a step enable comes every 2.5 ms.
`timescale 1ns/1ps
`include "mti_defines.svh"

module mti_in_filter
  import mti_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [10:0] raw_in,
  input wire logic [10:0] pol_mask,
  input wire logic [7:0] filt_const,
  input wire logic step,
  output logic [10:0] cond_out
);

  mti_filt_st_t st_ff;
  mti_filt_st_t nxt_st;
  logic [10:0] inv;

  // Level must be stable for filt_const steps before the output follows
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sync1 = raw_in;
    nxt_st.sync2 = st_ff.sync1;
    inv = st_ff.sync2 ^ pol_mask;
    for (int i = 0; i < 11; i++)
    begin
      if (inv[i] == st_ff.out[i])
        nxt_st.cnt[i] = 8'h00;
      else if (filt_const == 8'h00)
        nxt_st.out[i] = inv[i];
      else if (step)
      begin
        // One shared constant for all terminals, response about setting x 2.5 ms
        if (st_ff.cnt[i] + 8'h01 >= filt_const)
        begin
          nxt_st.out[i] = inv[i];
          nxt_st.cnt[i] = 8'h00;
        end
        else
          nxt_st.cnt[i] = st_ff.cnt[i] + 8'h01;
      end
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign cond_out = st_ff.out;

endmodule

// ===== rtl/mti_delay_timer.sv
// On/off delay timer driven by a conditioned terminal level.
// Assumes a one-cycle step enable every 0.1 s; delays are in 0.1 s units.
`timescale 1ns/1ps
`include "mti_defines.svh"

module mti_delay_timer
  import mti_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lvl_in,
  input wire logic step,
  input wire logic [15:0] on_dly,
  input wire logic [15:0] off_dly,
  output logic tmr_out
);

  mti_tmr_st_t st_ff;
  mti_tmr_st_t nxt_st;
  logic [15:0] dly;

  // A glitch shorter than the delay restarts the count, never flips the output
  always_comb
  begin
    nxt_st = st_ff;
    dly = lvl_in ? on_dly : off_dly;
    if (lvl_in == st_ff.out)
      nxt_st.cnt = 16'h0000;
    else if (step)
    begin
      if (st_ff.cnt + 16'h0001 >= dly)
      begin
        nxt_st.out = lvl_in;
        nxt_st.cnt = 16'h0000;
      end
      else
        nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tmr_out = st_ff.out;

endmodule

// ===== rtl/mti_top.sv
// Multifunction terminal block: conditions eleven inputs, dispatches their
// functions, drives four auxiliary outputs and holds the keypad registers.
// Assumes RUN_ACTIVE comes from drive logic on REF_CLK; terminals are async.
//
// Operation
// - Normally-closed trip input off while running: cut output, coast, report, flash stop.
// - External trip may be configured to latch instead of following the input.
// - Timer output follows timer input after on-delay and off-delay of 0.1-3600.0 s.
// - Gain-select input off uses first speed gain set, on uses second.
// - Premagnetize input asserted supplies no-load magnetizing current.
// - Torque-bias enable input applies bias only while on.
// - Torque offset source: none, analog, keypad or CAN.
// - No bias-enable input assigned: bias applies whenever source is not none.
// - Safety input enables or inhibits the PWM output stage.
// - Inputs default normally-open; eleven-bit inversion mask, reset all zeros.
// - Mask bits leftmost first: forward, reverse, block, reset, programmable 1 to 7.
// - Inverting the trip input turns it into a normally-open trip.
// - Polarity masks change only on an explicit write.
// - One low-pass setting for all inputs, response about setting times 2.5 ms.
// - Four-bit output inversion mask, leftmost is output one, default normally-open.
// - A function sits on one input only; duplicate assignment rejected.
// - Function assignments refused while the drive is running.
`timescale 1ns/1ps
`include "mti_defines.svh"

module mti_top
  import mti_pkg::*;
#(
  parameter int FILT_STEP_CYC = `MTI_FILT_STEP_CYC,
  parameter int TMR_STEP_CYC = `MTI_TMR_STEP_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [10:0] TERM_IN,
  input wire logic RUN_ACTIVE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic PWM_ENABLE,
  output logic COAST_STOP,
  output logic EXT_TRIP,
  output logic STOP_LED,
  output logic GAIN_SET_SECOND,
  output logic PREMAGNETIZE_EN,
  output logic TORQUE_OFFSET_EN,
  output logic [1:0] TORQUE_OFFSET_SOURCE,
  output logic BATTERY_RUN_EN,
  output logic [3:0] AUX_OUT,
  output logic IRQ
);

  mti_top_st_t st_ff;
  mti_top_st_t nxt_st;
  logic [10:0] cond;
  logic tmr_out;

  // Programmable terminal k (1..7) sits at bit 7-k of the terminal vector
  function automatic logic [6:0] fn_owner(input logic [6:0][4:0] func, input logic [4:0] code);
    logic [6:0] hit;
    hit = 7'h00;
    for (int k = 0; k < 7; k++)
      hit[k] = (code != `MTI_FN_NONE) && (func[k] == code);
    return hit;
  endfunction

  // Conditioned level of the terminal holding a code; zero when unassigned
  function automatic logic fn_level(input logic [6:0][4:0] func, input logic [4:0] code,
                                    input logic [10:0] c);
    logic [6:0] hit;
    logic lvl;
    hit = fn_owner(func, code);
    lvl = 1'b0;
    for (int k = 0; k < 7; k++)
      if (hit[k])
        lvl = c[6-k];
    return lvl;
  endfunction

  mti_in_filter u_filter (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .raw_in(TERM_IN),
    .pol_mask(st_ff.in_pol),
    .filt_const(st_ff.filt),
    .step(st_ff.filt_tick),
    .cond_out(cond)
  );

  mti_delay_timer u_timer (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .lvl_in(fn_level(st_ff.func, `MTI_FN_TIMER, cond)),
    .step(st_ff.tmr_tick),
    .on_dly(st_ff.tmr_on),
    .off_dly(st_ff.tmr_off),
    .tmr_out(tmr_out)
  );

  logic [2:0] ev;
  logic [6:0] owner;
  logic [2:0] fidx;
  logic trip_in;
  logic trip_clr;
  logic has_bias;
  logic has_safety;
  logic aux_val;

  always_comb
  begin
    nxt_st = st_ff;
    ev = 3'h0;
    owner = 7'h00;
    fidx = 3'h0;
    aux_val = 1'b0;

    // Step enables: 2.5 ms filter step and 0.1 s timer step
    nxt_st.filt_tick = 1'b0;
    nxt_st.tmr_tick = 1'b0;
    if (st_ff.filt_div >= 32'(FILT_STEP_CYC - 1))
    begin
      nxt_st.filt_div = 32'h00000000;
      nxt_st.filt_tick = 1'b1;
    end
    else
      nxt_st.filt_div = st_ff.filt_div + 32'h00000001;
    if (st_ff.tmr_div >= 32'(TMR_STEP_CYC - 1))
    begin
      nxt_st.tmr_div = 32'h00000000;
      nxt_st.tmr_tick = 1'b1;
    end
    else
      nxt_st.tmr_div = st_ff.tmr_div + 32'h00000001;

    // External trip: normally-closed sense, so an inactive level trips
    trip_in = (|fn_owner(st_ff.func, `MTI_FN_EXT_TRIP)) &&
              !fn_level(st_ff.func, `MTI_FN_EXT_TRIP, cond);
    trip_clr = cond[`MTI_T_RST] ||
               (WR && ADDR == `MTI_REG_CTRL && WDATA[`MTI_CTRL_TRIP_CLR]);
    if (st_ff.latch)
    begin
      // Latched trip holds until the fault reset terminal or a clear write
      if (trip_in && (RUN_ACTIVE || st_ff.trip))
        nxt_st.trip = 1'b1;
      else if (trip_clr)
        nxt_st.trip = 1'b0;
    end
    else
      nxt_st.trip = trip_in && (RUN_ACTIVE || st_ff.trip);
    ev[`MTI_IRQ_TRIP] = nxt_st.trip && !st_ff.trip;
    if (st_ff.tmr_tick)
      nxt_st.flash = st_ff.trip ? !st_ff.flash : 1'b0;

    // Timer output rise event
    nxt_st.tmr_q = tmr_out;
    ev[`MTI_IRQ_TIMER] = tmr_out && !st_ff.tmr_q;

    // Function dispatch
    nxt_st.gain2 = fn_level(st_ff.func, `MTI_FN_GAIN, cond);
    nxt_st.premag = fn_level(st_ff.func, `MTI_FN_PREMAG, cond);
    nxt_st.battery = fn_level(st_ff.func, `MTI_FN_BATTERY, cond);
    has_bias = |fn_owner(st_ff.func, `MTI_FN_TRQ_BIAS);
    if (st_ff.src == MTI_SRC_NONE)
      nxt_st.bias_en = 1'b0;
    else if (has_bias)
      nxt_st.bias_en = fn_level(st_ff.func, `MTI_FN_TRQ_BIAS, cond);
    else
      nxt_st.bias_en = 1'b1;
    has_safety = |fn_owner(st_ff.func, `MTI_FN_SAFETY);
    nxt_st.pwm_en = !nxt_st.trip &&
                    (!has_safety || fn_level(st_ff.func, `MTI_FN_SAFETY, cond));
    nxt_st.coast = nxt_st.trip;

    // Auxiliary outputs: evaluate the function, then apply inversion
    for (int i = 0; i < 4; i++)
    begin
      case (mti_aux_t'(st_ff.aux_sel[i]))
        MTI_AUX_TIMER: aux_val = tmr_out;
        MTI_AUX_TRIP: aux_val = st_ff.trip;
        MTI_AUX_RUN: aux_val = RUN_ACTIVE;
        default: aux_val = 1'b0;
      endcase
      nxt_st.aux[3-i] = aux_val ^ st_ff.out_pol[3-i];
    end

    // Register writes; masks change only here
    if (WR)
    begin
      case (ADDR)
        `MTI_REG_CTRL:
        begin
          nxt_st.latch = WDATA[`MTI_CTRL_LATCH];
          nxt_st.src = WDATA[`MTI_CTRL_SRC_LO +: 2];
        end
        `MTI_REG_IN_POL: nxt_st.in_pol = WDATA[10:0];
        `MTI_REG_OUT_POL: nxt_st.out_pol = WDATA[3:0];
        `MTI_REG_FILT: nxt_st.filt = WDATA[7:0];
        `MTI_REG_TMR_ON: nxt_st.tmr_on = WDATA[15:0];
        `MTI_REG_TMR_OFF: nxt_st.tmr_off = WDATA[15:0];
        `MTI_REG_AUX_SEL: nxt_st.aux_sel = WDATA[7:0];
        `MTI_REG_IRQ_MASK: nxt_st.irq_mask = WDATA[2:0];
        default:
        begin
          if (ADDR >= `MTI_REG_FUNC_BASE && ADDR <= `MTI_REG_FUNC_LAST && ADDR[1:0] == 2'b00)
          begin
            fidx = 3'(ADDR[7:2] - 6'h10);
            owner = fn_owner(st_ff.func, WDATA[4:0]);
            owner[fidx] = 1'b0;
            // Refused while running or when another terminal owns the code
            if (RUN_ACTIVE || (|owner))
              ev[`MTI_IRQ_REJECT] = 1'b1;
            else
              nxt_st.func[fidx] = WDATA[4:0];
          end
        end
      endcase
    end

    // Sticky status: write one to clear, but a new event wins over the clear
    if (WR && ADDR == `MTI_REG_IRQ_STAT)
      nxt_st.irq_stat = st_ff.irq_stat & ~WDATA[2:0];
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

    // Read data stands in the cycle after the read strobe only
    nxt_st.rdata = 32'h00000000;
    if (RD)
    begin
      case (ADDR)
        `MTI_REG_CTRL: nxt_st.rdata = {28'h0000000, 1'b0, st_ff.src, st_ff.latch};
        `MTI_REG_IN_POL: nxt_st.rdata = {21'h000000, st_ff.in_pol};
        `MTI_REG_OUT_POL: nxt_st.rdata = {28'h0000000, st_ff.out_pol};
        `MTI_REG_FILT: nxt_st.rdata = {24'h000000, st_ff.filt};
        `MTI_REG_TMR_ON: nxt_st.rdata = {16'h0000, st_ff.tmr_on};
        `MTI_REG_TMR_OFF: nxt_st.rdata = {16'h0000, st_ff.tmr_off};
        `MTI_REG_AUX_SEL: nxt_st.rdata = {24'h000000, st_ff.aux_sel};
        `MTI_REG_STATUS: nxt_st.rdata = {11'h000, st_ff.aux, st_ff.pwm_en, st_ff.bias_en,
                                         st_ff.premag, st_ff.gain2, tmr_out, st_ff.trip,
                                         cond};
        `MTI_REG_IRQ_STAT: nxt_st.rdata = {29'h00000000, st_ff.irq_stat};
        `MTI_REG_IRQ_MASK: nxt_st.rdata = {29'h00000000, st_ff.irq_mask};
        default:
        begin
          if (ADDR >= `MTI_REG_FUNC_BASE && ADDR <= `MTI_REG_FUNC_LAST && ADDR[1:0] == 2'b00)
            nxt_st.rdata = {27'h0000000, st_ff.func[3'(ADDR[7:2] - 6'h10)]};
        end
      endcase
    end
  end

  // Whole block state in one register; only constants under reset
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_ff <= '0;
      st_ff.in_pol <= `MTI_IN_POL_RST;
      st_ff.out_pol <= `MTI_OUT_POL_RST;
      st_ff.filt <= `MTI_FILT_RST;
      st_ff.tmr_on <= `MTI_TMR_RST;
      st_ff.tmr_off <= `MTI_TMR_RST;
      st_ff.pwm_en <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // Ports straight from flip-flops
  assign RDATA = st_ff.rdata;
  assign PWM_ENABLE = st_ff.pwm_en;
  assign COAST_STOP = st_ff.coast;
  assign EXT_TRIP = st_ff.trip;
  assign STOP_LED = st_ff.flash;
  assign GAIN_SET_SECOND = st_ff.gain2;
  assign PREMAGNETIZE_EN = st_ff.premag;
  assign TORQUE_OFFSET_EN = st_ff.bias_en;
  assign TORQUE_OFFSET_SOURCE = st_ff.src;
  assign BATTERY_RUN_EN = st_ff.battery;
  assign AUX_OUT = st_ff.aux;
  assign IRQ = st_ff.irq;

endmodule

// ===== sim/mti_contacts.sv
// Partner model: the switches and relay contacts wired to the eleven terminals.
// Assumes the bench commands each contact; a closed contact reads high.
`timescale 1ns/1ps

module mti_contacts
(
  input wire logic [10:0] closed,
  output logic [10:0] term
);
  // Contacts settle a few ns after the command, so never on a sampling edge
  assign #3 term = closed;
endmodule

// ===== sim/mti_checker.sv
// Port-level assertions for the terminal block, attached to mti_top by bind.
// Assumes the single REF_CLK domain and RESET_N asynchronous, active low.
`timescale 1ns/1ps

module mti_checker
#(
  parameter int TMR_STEP_CYC = 8
)
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic RUN_ACTIVE,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic PWM_ENABLE,
  input wire logic COAST_STOP,
  input wire logic EXT_TRIP,
  input wire logic STOP_LED,
  input wire logic TORQUE_OFFSET_EN,
  input wire logic [1:0] TORQUE_OFFSET_SOURCE,
  input wire logic [3:0] AUX_OUT
);
  logic [31:0] gap_ff;

  // Cycles since the stop lamp last changed while tripped; a counter, as a step is long
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      gap_ff <= 32'h0;
    else if (!EXT_TRIP || (STOP_LED != $past(STOP_LED)))
      gap_ff <= 32'h0;
    else
      gap_ff <= gap_ff + 32'h1;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  chk_coast_trip: assert property (COAST_STOP == EXT_TRIP)
    else $error("coast stop differs from trip state");
  chk_pwm_cut: assert property (EXT_TRIP && $past(EXT_TRIP) |-> !PWM_ENABLE)
    else $error("output stage enabled while tripped");
  chk_trip_running: assert property ($rose(EXT_TRIP) |-> $past(RUN_ACTIVE) || $past(RUN_ACTIVE, 2))
    else $error("trip raised while stopped");
  chk_lamp_flash: assert property (gap_ff <= 2 * TMR_STEP_CYC)
    else $error("stop lamp not flashing while tripped");
  chk_bias_none: assert property (TORQUE_OFFSET_SOURCE == 2'h0 && $past(TORQUE_OFFSET_SOURCE) == 2'h0 |-> !TORQUE_OFFSET_EN)
    else $error("torque offset on with no source");
  chk_source_hold: assert property (!WR && !$past(WR) |=> $stable(TORQUE_OFFSET_SOURCE))
    else $error("offset source moved without a write");
  chk_reset_state: assert property ($rose(RESET_N) |-> PWM_ENABLE && AUX_OUT == 4'h0 && !EXT_TRIP)
    else $error("outputs wrong after reset");
  chk_read_quiet: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside the answer cycle");

  cover property ($rose(EXT_TRIP));
  cover property ($rose(STOP_LED));
  cover property (RD ##1 RDATA != 32'h0);
endmodule

bind mti_top mti_checker #(.TMR_STEP_CYC(TMR_STEP_CYC)) chk_u
(
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .RUN_ACTIVE(RUN_ACTIVE), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PWM_ENABLE(PWM_ENABLE), .COAST_STOP(COAST_STOP), .EXT_TRIP(EXT_TRIP),
  .STOP_LED(STOP_LED), .TORQUE_OFFSET_EN(TORQUE_OFFSET_EN),
  .TORQUE_OFFSET_SOURCE(TORQUE_OFFSET_SOURCE), .AUX_OUT(AUX_OUT)
);

// ===== sim/multifunction_terminal_io_bench.sv
// Self-checking bench: register tasks on the plain port, contacts via the partner.
// Assumes mti_top with short steps: filter step 4 cycles, timer step 8 cycles.
`timescale 1ns/1ps
`include "mti_defines.svh"

module multifunction_terminal_io_bench;
  import mti_pkg::*;
  logic ref_clk, reset_n, run_active, wr, rd;
  logic [10:0] closed, term_in;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic pwm, coast, trip, led, gain2, premag, bias_en, battery, irq;
  logic [1:0] src;
  logic [3:0] aux;
  int errors = 0;
  int check_count = 0;
  int i;

  mti_contacts sw_u (.closed(closed), .term(term_in));
  mti_top #(.FILT_STEP_CYC(4), .TMR_STEP_CYC(8)) dut_u
  (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .TERM_IN(term_in), .RUN_ACTIVE(run_active),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PWM_ENABLE(pwm),
    .COAST_STOP(coast), .EXT_TRIP(trip), .STOP_LED(led), .GAIN_SET_SECOND(gain2),
    .PREMAGNETIZE_EN(premag), .TORQUE_OFFSET_EN(bias_en), .TORQUE_OFFSET_SOURCE(src),
    .BATTERY_RUN_EN(battery), .AUX_OUT(aux), .IRQ(irq)
  );

  // 20 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      begin
        errors++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check(rdata & m, exp);
  endtask

  // Move one contact, then allow synchroniser and output stage to settle
  task automatic term(input int b, input logic v);
    @(posedge ref_clk);
    closed[b] <= v;
    cyc(6);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #400000;
    errors++;
    test_done();
  end

  initial
  begin
    reset_n = 1'b0;
    run_active = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    closed = 11'h000;
    cyc(2);
    reset_n <= 1'b1;
    rd_reg(`MTI_REG_IN_POL, 32'h0, 32'h7FF);
    rd_reg(`MTI_REG_OUT_POL, 32'h0, 32'hF);
    rd_reg(`MTI_REG_FILT, 32'h4, 32'hFF);
    rd_reg(`MTI_REG_TMR_ON, 32'h1, 32'hFFFF);
    wr_reg(8'h30, 32'hFF);
    rd_reg(8'h30, 32'h0, 32'hFFFFFFFF);
    $display("test reset values done");
    wr_reg(`MTI_REG_FILT, 32'h0);
    wr_reg(`MTI_REG_IN_POL, 32'h042);
    term(`MTI_T_FWD, 1'b1);
    rd_reg(`MTI_REG_STATUS, 32'h442, 32'h7FF);
    wr_reg(`MTI_REG_FUNC_BASE, `MTI_FN_GAIN);
    cyc(6);
    chk1(gain2, 1'b1);
    term(6, 1'b1);
    chk1(gain2, 1'b0);
    rd_reg(`MTI_REG_IN_POL, 32'h042, 32'h7FF);
    $display("test polarity and gain done");
    wr_reg(8'h44, `MTI_FN_GAIN);
    rd_reg(8'h44, 32'h0, 32'h1F);
    wr_reg(`MTI_REG_IRQ_MASK, 32'h2);
    cyc(2);
    chk1(irq, 1'b1);
    wr_reg(`MTI_REG_IRQ_STAT, 32'h2);
    cyc(2);
    chk1(irq, 1'b0);
    run_active <= 1'b1;
    wr_reg(8'h48, `MTI_FN_PREMAG);
    rd_reg(8'h48, 32'h0, 32'h1F);
    run_active <= 1'b0;
    wr_reg(`MTI_REG_IRQ_STAT, 32'h7);
    $display("test assignment refusal done");
    wr_reg(8'h48, `MTI_FN_PREMAG);
    term(4, 1'b1);
    chk1(premag, 1'b1);
    term(4, 1'b0);
    chk1(premag, 1'b0);
    for (i = 0; i < 4; i++)
      begin
        wr_reg(`MTI_REG_CTRL, 32'(i) << `MTI_CTRL_SRC_LO);
        cyc(3);
        check({30'h0, src}, 32'(i));
        chk1(bias_en, i != 0);
      end
    wr_reg(`MTI_REG_CTRL, 32'h4);
    wr_reg(8'h4C, `MTI_FN_TRQ_BIAS);
    cyc(6);
    chk1(bias_en, 1'b0);
    term(3, 1'b1);
    chk1(bias_en, 1'b1);
    $display("test premagnetize and bias done");
    term(2, 1'b1);
    wr_reg(8'h50, `MTI_FN_EXT_TRIP);
    run_active <= 1'b1;
    term(2, 1'b0);
    chk1(trip, 1'b1);
    chk1(coast, 1'b1);
    chk1(pwm, 1'b0);
    cyc(30);
    rd_reg(`MTI_REG_IRQ_STAT, 32'h1, 32'h1);
    term(2, 1'b1);
    chk1(trip, 1'b0);
    wr_reg(`MTI_REG_CTRL, 32'h5);
    term(2, 1'b0);
    term(2, 1'b1);
    chk1(trip, 1'b1);
    wr_reg(`MTI_REG_CTRL, 32'hD);
    cyc(3);
    chk1(trip, 1'b0);
    wr_reg(`MTI_REG_IN_POL, 32'h004);
    cyc(6);
    chk1(trip, 1'b1);
    term(2, 1'b0);
    wr_reg(`MTI_REG_CTRL, 32'hD);
    cyc(3);
    chk1(trip, 1'b0);
    run_active <= 1'b0;
    wr_reg(8'h54, `MTI_FN_SAFETY);
    cyc(6);
    chk1(pwm, 1'b0);
    term(1, 1'b1);
    chk1(pwm, 1'b1);
    wr_reg(8'h44, `MTI_FN_BATTERY);
    cyc(6);
    chk1(battery, 1'b0);
    term(5, 1'b1);
    chk1(battery, 1'b1);
    $display("test trip and safety done");
    wr_reg(`MTI_REG_FUNC_LAST, `MTI_FN_TIMER);
    wr_reg(`MTI_REG_TMR_ON, 32'h3);
    wr_reg(`MTI_REG_TMR_OFF, 32'h2);
    wr_reg(`MTI_REG_AUX_SEL, 32'h1);
    wr_reg(`MTI_REG_OUT_POL, 32'h5);
    cyc(3);
    check({28'h0, aux}, 32'h5);
    term(0, 1'b1);
    check({28'h0, aux}, 32'h5);
    for (i = 0; i < 60 && aux[3] !== 1'b1; i++)
      cyc(1);
    chk1(i >= 10 && i <= 28, 1'b1);
    check({28'h0, aux}, 32'hD);
    term(0, 1'b0);
    for (i = 0; i < 60 && aux[3] !== 1'b0; i++)
      cyc(1);
    chk1(i >= 2 && i <= 22, 1'b1);
    rd_reg(`MTI_REG_IRQ_STAT, 32'h4, 32'h4);
    $display("test timer and aux done");
    wr_reg(`MTI_REG_FILT, 32'h3);
    term(9, 1'b1);
    term(9, 1'b0);
    cyc(16);
    rd_reg(`MTI_REG_STATUS, 32'h0, 32'h200);
    term(9, 1'b1);
    rd_reg(`MTI_REG_STATUS, 32'h0, 32'h200);
    cyc(12);
    rd_reg(`MTI_REG_STATUS, 32'h200, 32'h200);
    $display("test filter done");
    test_done();
  end
endmodule
